//--- thzal_pkg.sv
/*
 * Shared constants and types for the thermal zone alert logic.
 * Assumes a bus engine on the link clock and an ADC on the core clock.
 */
package thzal_pkg;

    // Zone indices into the per-zone arrays.
    localparam int THZAL_ZONES = 3;
    localparam int THZAL_ZONE_LOCAL = 0;
    localparam int THZAL_ZONE_R1 = 1;
    localparam int THZAL_ZONE_R2 = 2;

    // Threshold reset values, two's complement degrees.
    localparam logic [7:0] THZAL_HI_LOCAL_RST = 8'h51;
    localparam logic [7:0] THZAL_LO_LOCAL_RST = 8'h4C;
    localparam logic [7:0] THZAL_HI_REMOTE_RST = 8'h61;
    localparam logic [7:0] THZAL_LO_REMOTE_RST = 8'h5C;
    localparam logic [7:0] THZAL_READING_RST = 8'h00;
    localparam logic [7:0] THZAL_DIODE_LIMIT = 8'h7F;
    localparam logic [7:0] THZAL_RD_NONE = 8'h00;

    // Register command bytes.
    localparam logic [7:0] THZAL_CMD_TEMP0 = 8'h00;
    localparam logic [7:0] THZAL_CMD_CONFIG = 8'h01;
    localparam logic [7:0] THZAL_CMD_HYST0 = 8'h02;
    localparam logic [7:0] THZAL_CMD_SET0 = 8'h03;
    localparam logic [7:0] THZAL_CMD_TEMP1 = 8'h10;
    localparam logic [7:0] THZAL_CMD_HYST1 = 8'h12;
    localparam logic [7:0] THZAL_CMD_SET1 = 8'h13;
    localparam logic [7:0] THZAL_CMD_TEMP2 = 8'h20;
    localparam logic [7:0] THZAL_CMD_HYST2 = 8'h22;
    localparam logic [7:0] THZAL_CMD_SET2 = 8'h23;

    // Configuration byte field positions.
    localparam int THZAL_CFG_HALT = 0;
    localparam int THZAL_CFG_MODE = 1;
    localparam int THZAL_CFG_MASK = 2;
    localparam int THZAL_CFG_DEPTH_LO = 3;
    localparam int THZAL_CFG_DEPTH_HI = 4;
    localparam int THZAL_CFG_FLAG_Z2 = 5;
    localparam int THZAL_CFG_FLAG_Z1 = 6;
    localparam int THZAL_CFG_FLAG_LOCAL = 7;

    // Filter depth codes and their run lengths.
    localparam logic [1:0] THZAL_DEPTH_1 = 2'h0;
    localparam logic [1:0] THZAL_DEPTH_2 = 2'h1;
    localparam logic [1:0] THZAL_DEPTH_4 = 2'h2;
    localparam logic [1:0] THZAL_DEPTH_6 = 2'h3;
    localparam logic [2:0] THZAL_RUN_1 = 3'h1;
    localparam logic [2:0] THZAL_RUN_2 = 3'h2;
    localparam logic [2:0] THZAL_RUN_4 = 3'h4;
    localparam logic [2:0] THZAL_RUN_6 = 3'h6;
    localparam logic [2:0] THZAL_RUN_ZERO = 3'h0;
    localparam logic [2:0] THZAL_RUN_STEP = 3'h1;

    // Zone codes shown to the ADC.
    localparam logic [1:0] THZAL_ZCODE_LOCAL = 2'h0;
    localparam logic [1:0] THZAL_ZCODE_R1 = 2'h1;
    localparam logic [1:0] THZAL_ZCODE_R2 = 2'h2;

    // Strap synchroniser fill count before capture.
    localparam logic [1:0] THZAL_ADDR_FILL = 2'h3;
    localparam logic [1:0] THZAL_ADDR_STEP = 2'h1;

    // Conversion sequencer states.
    typedef enum logic [2:0] {
        THZAL_SEQ_Z1 = 3'b001,
        THZAL_SEQ_Z2 = 3'b010,
        THZAL_SEQ_Z0 = 3'b100
    } thzal_seq_e;

    // One register request from the bus engine.
    typedef struct packed {
        logic write;
        logic [7:0] cmd;
        logic [7:0] data;
    } thzal_req_s;

    // Core domain state of the alert logic.
    typedef struct packed {
        logic [2:0][7:0] hiTh;
        logic [2:0][7:0] loTh;
        logic [2:0][7:0] reading;
        logic [2:0][2:0] runCount;
        logic [2:0] flags;
        logic [2:0] armedOver;
        logic halt;
        logic mode;
        logic mask;
        logic [1:0] depth;
        logic intAlert;
        logic alertOe;
        logic alertLow;
        thzal_seq_e seq;
        logic [1:0] zoneCode;
        logic run;
        logic restart;
        logic [1:0] addrSync;
        logic [1:0] addrFill;
        logic addrBit;
        logic [1:0] pinSync;
    } thzal_core_s;

    // Link domain state of the request handshake.
    typedef struct packed {
        thzal_req_s hold;
        logic reqTog;
        logic busy;
        logic [2:0] ackSync;
        logic [7:0] rdData;
        logic rdValid;
    } thzal_link_s;

    // Core domain receive side of the request handshake.
    typedef struct packed {
        logic [2:0] reqSync;
        logic ackTog;
        logic [7:0] rdHold;
    } thzal_rx_s;

endpackage

//--- thzal_link_cdc.sv
/*
 * Request and answer handshake between the bus engine on the link clock
 * and the alert logic on the core clock.
 * Assumes each reset is synchronous to its own clock.
 */
`timescale 1ns/10ps
module thzal_link_cdc
    import thzal_pkg::*;
(
    input wire logic linkClock,
    input wire logic linkRst_b,
    input wire logic busReq,
    input wire thzal_req_s busReqData,
    output logic linkReady,
    output logic [7:0] busRdData,
    output logic busRdValid,
    input wire logic clock,
    input wire logic rst_b,
    output logic coreReq,
    output thzal_req_s coreReqData,
    input wire logic [7:0] coreRdData
);

    thzal_link_s l_reg;
    thzal_link_s l_next;
    thzal_rx_s r_reg;
    thzal_rx_s r_next;
    logic ackEdge;

    // Link side holds a request steady until the core acknowledges it.
    assign ackEdge = l_reg.ackSync[2] ^ l_reg.ackSync[1];

    always_comb begin
        l_next = l_reg;
        l_next.rdValid = 1'b0;
        l_next.ackSync = {l_reg.ackSync[1:0], r_reg.ackTog};
        if (busReq && !l_reg.busy) begin
            l_next.hold = busReqData;
            l_next.reqTog = ~l_reg.reqTog;
            l_next.busy = 1'b1;
        end
        if (ackEdge) begin
            l_next.busy = 1'b0;
            l_next.rdData = r_reg.rdHold;
            l_next.rdValid = ~l_reg.hold.write;
        end
    end

    always_ff @(posedge linkClock) begin
        if (!linkRst_b) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    // Core side sees one pulse per request and returns the read byte.
    assign coreReq = r_reg.reqSync[2] ^ r_reg.reqSync[1];
    assign coreReqData = l_reg.hold;

    always_comb begin
        r_next = r_reg;
        r_next.reqSync = {r_reg.reqSync[1:0], l_reg.reqTog};
        if (coreReq) begin
            r_next.rdHold = coreRdData;
            r_next.ackTog = ~r_reg.ackTog;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Link side outputs come straight from link domain flops.
    assign linkReady = ~l_reg.busy;
    assign busRdData = l_reg.rdData;
    assign busRdValid = l_reg.rdValid;

endmodule

//--- thermal_zone_alert_logic.sv
/*
 * Temperature event and alert logic of a three zone thermal supervisor:
 * per zone filters, sticky flags, open drain alert, halt, strap capture.
 * Assumes an ADC on the core clock and a bus engine on the link clock.
 */
// Function
// - Reset gives running, comparator style, depth code 00, alert unmasked.
// - Reset thresholds: local 81 high 76 low, remotes 97 high 92 low.
// - Address select pin is captured once after reset, then held.
// - Mode bit chooses thermostat level or latched interrupt alert.
// - Alert asserts after depth consecutive readings above a zone's high threshold.
// - Comparator style releases only after depth readings below low threshold.
// - Comparator style keeps the alert level unchanged through halt.
// - Interrupt style holds alert until any read and flag until a configuration read; halt entry clears both.
// - Interrupt style alternates: over event, then under event, then over.
// - Every zone detector starts armed for over temperature.
// - Halt stops conversions; registers stay readable and writable.
// - Halt entry in interrupt style clears alert and flags; halted detects nothing.
// - Depth code 00,01,10,11 means 1,2,4,6 consecutive conversions.
// - Each zone has its own run counter; a broken run restarts it.
// - Over and fault events set flags even when masked; mask blocks the level alert and new latched alerts.
// - In interrupt style any read releases the alert; only a configuration read or halt entry clears flags.
// - Each zone's crossing sets that zone's own flag and asserts alert.
// - Remote sense fault sets that zone's flag if high threshold below 127.
// - Repeated events before a configuration read leave one set flag.
// - Conversions cycle zone one, zone two, local; bus access restarts one.
// - Readings and thresholds are signed bytes, one degree per step.
// - Mode bit one is interrupt style, zero is comparator style.
`timescale 1ns/10ps
module thermal_zone_alert_logic
    import thzal_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic linkClock,
    input wire logic linkRst_b,
    input wire logic busReq,
    input wire thzal_req_s busReqData,
    output logic linkReady,
    output logic [7:0] busRdData,
    output logic busRdValid,
    input wire logic convDone,
    input wire logic [7:0] convReading,
    input wire logic convFault,
    output logic convRun,
    output logic [1:0] convZone,
    output logic convRestart,
    input wire logic addrSelectPin,
    output logic clientAddrBit,
    input wire logic alertPinIn,
    output logic alertPinOut,
    output logic alertPinOe,
    output logic alertSensed,
    output logic haltActive,
    output logic [2:0] zoneFlags
);

    thzal_core_s s_reg;
    thzal_core_s s_next;
    logic coreReq;
    thzal_req_s coreReqData;
    logic [7:0] coreRdData;
    logic isRead;
    logic isWrite;
    logic cfgRead;
    logic cfgWrite;
    logic haltEnter;
    logic haltExit;
    logic takeConv;
    logic condMet;
    logic evOver;
    logic evUnder;
    logic evFault;
    logic [2:0] runNext;
    int zone;

    // Run length that a depth code asks for.
    function automatic logic [2:0] depthRun(input logic [1:0] code);
        case (code)
            THZAL_DEPTH_1: depthRun = THZAL_RUN_1;
            THZAL_DEPTH_2: depthRun = THZAL_RUN_2;
            THZAL_DEPTH_4: depthRun = THZAL_RUN_4;
            THZAL_DEPTH_6: depthRun = THZAL_RUN_6;
            default: depthRun = THZAL_RUN_1;
        endcase
    endfunction

    // Zone array index of a sequencer state.
    function automatic int seqZone(input thzal_seq_e st);
        case (st)
            THZAL_SEQ_Z1: seqZone = THZAL_ZONE_R1;
            THZAL_SEQ_Z2: seqZone = THZAL_ZONE_R2;
            THZAL_SEQ_Z0: seqZone = THZAL_ZONE_LOCAL;
            default: seqZone = THZAL_ZONE_R1;
        endcase
    endfunction

    // Zone code shown to the ADC for a sequencer state.
    function automatic logic [1:0] seqCode(input thzal_seq_e st);
        case (st)
            THZAL_SEQ_Z1: seqCode = THZAL_ZCODE_R1;
            THZAL_SEQ_Z2: seqCode = THZAL_ZCODE_R2;
            THZAL_SEQ_Z0: seqCode = THZAL_ZCODE_LOCAL;
            default: seqCode = THZAL_ZCODE_R1;
        endcase
    endfunction

    // Next zone in the conversion sequence.
    function automatic thzal_seq_e seqNext(input thzal_seq_e st);
        case (st)
            THZAL_SEQ_Z1: seqNext = THZAL_SEQ_Z2;
            THZAL_SEQ_Z2: seqNext = THZAL_SEQ_Z0;
            THZAL_SEQ_Z0: seqNext = THZAL_SEQ_Z1;
            default: seqNext = THZAL_SEQ_Z1;
        endcase
    endfunction

    // Crossing of bus requests and read answers between the clocks.
    thzal_link_cdc u_link (
        .linkClock(linkClock),
        .linkRst_b(linkRst_b),
        .busReq(busReq),
        .busReqData(busReqData),
        .linkReady(linkReady),
        .busRdData(busRdData),
        .busRdValid(busRdValid),
        .clock(clock),
        .rst_b(rst_b),
        .coreReq(coreReq),
        .coreReqData(coreReqData),
        .coreRdData(coreRdData)
    );

    // Decode of the request that the crossing presents this cycle.
    assign isRead = coreReq & ~coreReqData.write;
    assign isWrite = coreReq & coreReqData.write;
    assign cfgRead = isRead & (coreReqData.cmd == THZAL_CMD_CONFIG);
    assign cfgWrite = isWrite & (coreReqData.cmd == THZAL_CMD_CONFIG);
    assign haltEnter = cfgWrite & coreReqData.data[THZAL_CFG_HALT] & ~s_reg.halt;
    assign haltExit = cfgWrite & ~coreReqData.data[THZAL_CFG_HALT] & s_reg.halt;

    // A result is used only while running and when no bus access cut it.
    assign takeConv = convDone & ~s_reg.halt & ~coreReq;
    assign zone = seqZone(s_reg.seq);

    // Readback of the register named by the current request.
    always_comb begin
        case (coreReqData.cmd)
            THZAL_CMD_TEMP0: coreRdData = s_reg.reading[THZAL_ZONE_LOCAL];
            THZAL_CMD_CONFIG: coreRdData = {s_reg.flags[THZAL_ZONE_LOCAL],
                s_reg.flags[THZAL_ZONE_R1], s_reg.flags[THZAL_ZONE_R2],
                s_reg.depth, s_reg.mask, s_reg.mode, s_reg.halt};
            THZAL_CMD_HYST0: coreRdData = s_reg.loTh[THZAL_ZONE_LOCAL];
            THZAL_CMD_SET0: coreRdData = s_reg.hiTh[THZAL_ZONE_LOCAL];
            THZAL_CMD_TEMP1: coreRdData = s_reg.reading[THZAL_ZONE_R1];
            THZAL_CMD_HYST1: coreRdData = s_reg.loTh[THZAL_ZONE_R1];
            THZAL_CMD_SET1: coreRdData = s_reg.hiTh[THZAL_ZONE_R1];
            THZAL_CMD_TEMP2: coreRdData = s_reg.reading[THZAL_ZONE_R2];
            THZAL_CMD_HYST2: coreRdData = s_reg.loTh[THZAL_ZONE_R2];
            THZAL_CMD_SET2: coreRdData = s_reg.hiTh[THZAL_ZONE_R2];
            default: coreRdData = THZAL_RD_NONE;
        endcase
    end

    // Filter step for the zone whose conversion just finished.
    always_comb begin
        condMet = 1'b0;
        evOver = 1'b0;
        evUnder = 1'b0;
        evFault = 1'b0;
        runNext = THZAL_RUN_ZERO;
        if (takeConv && convFault) begin
            // A sense fault only counts when the high threshold is below 127.
            evFault = (zone != THZAL_ZONE_LOCAL) &&
                ($signed(s_reg.hiTh[zone]) < $signed(THZAL_DIODE_LIMIT));
        end else if (takeConv) begin
            if (s_reg.armedOver[zone]) begin
                condMet = $signed(convReading) >
                    $signed(s_reg.hiTh[zone]);
            end else begin
                condMet = $signed(convReading) <
                    $signed(s_reg.loTh[zone]);
            end
            if (condMet) begin
                runNext = s_reg.runCount[zone] + THZAL_RUN_STEP;
                if (runNext >= depthRun(s_reg.depth)) begin
                    evOver = s_reg.armedOver[zone];
                    evUnder = ~s_reg.armedOver[zone];
                    runNext = THZAL_RUN_ZERO;
                end
            end
        end
    end

    // Next state of the whole block.
    always_comb begin
        s_next = s_reg;
        s_next.restart = 1'b0;
        s_next.alertLow = 1'b0;

        // Strap capture after the synchroniser has filled.
        s_next.addrSync = {s_reg.addrSync[0], addrSelectPin};
        s_next.pinSync = {s_reg.pinSync[0], alertPinIn};
        if (s_reg.addrFill != THZAL_ADDR_FILL) begin
            s_next.addrFill = s_reg.addrFill + THZAL_ADDR_STEP;
            s_next.addrBit = s_reg.addrSync[1];
        end

        // Register writes; readings are not writable.
        if (cfgWrite) begin
            s_next.halt = coreReqData.data[THZAL_CFG_HALT];
            s_next.mode = coreReqData.data[THZAL_CFG_MODE];
            s_next.mask = coreReqData.data[THZAL_CFG_MASK];
            s_next.depth = coreReqData.data[THZAL_CFG_DEPTH_HI:
                THZAL_CFG_DEPTH_LO];
        end
        if (isWrite) begin
            case (coreReqData.cmd)
                THZAL_CMD_HYST0: s_next.loTh[THZAL_ZONE_LOCAL] = coreReqData.data;
                THZAL_CMD_SET0: s_next.hiTh[THZAL_ZONE_LOCAL] = coreReqData.data;
                THZAL_CMD_HYST1: s_next.loTh[THZAL_ZONE_R1] = coreReqData.data;
                THZAL_CMD_SET1: s_next.hiTh[THZAL_ZONE_R1] = coreReqData.data;
                THZAL_CMD_HYST2: s_next.loTh[THZAL_ZONE_R2] = coreReqData.data;
                THZAL_CMD_SET2: s_next.hiTh[THZAL_ZONE_R2] = coreReqData.data;
                default: s_next.mask = s_next.mask;
            endcase
        end

        // Clears first; a result during a bus access is dropped, so no event meets a clear.
        if (s_reg.mode && isRead) begin
            s_next.intAlert = 1'b0;
        end
        if (s_reg.mode && cfgRead) begin
            s_next.flags = '0;
        end
        if (haltEnter && coreReqData.data[THZAL_CFG_MODE]) begin
            s_next.intAlert = 1'b0;
            s_next.flags = '0;
        end

        // Conversion bookkeeping and events of the finished zone.
        if (takeConv) begin
            s_next.seq = seqNext(s_reg.seq);
            s_next.runCount[zone] = runNext;
            if (!convFault) begin
                s_next.reading[zone] = convReading;
            end
        end
        if (evOver || evUnder) begin
            s_next.armedOver[zone] = evUnder;
        end
        if (s_reg.mode) begin
            // Interrupt style: every event sets its zone's sticky flag.
            if (evOver || evUnder || evFault) begin
                s_next.flags[zone] = 1'b1;
                if (!s_reg.mask) begin
                    s_next.intAlert = 1'b1;
                end
            end
        end else begin
            // Comparator style: the flag follows the filtered over state.
            if (evOver || evFault) begin
                s_next.flags[zone] = 1'b1;
            end
            if (evUnder) begin
                s_next.flags[zone] = 1'b0;
            end
        end

        // Bus access restarts the running conversion; wake starts at zone one.
        if (coreReq && !s_reg.halt && !haltEnter) begin
            s_next.restart = 1'b1;
        end
        if (haltExit) begin
            s_next.seq = THZAL_SEQ_Z1;
            s_next.restart = 1'b1;
        end
        s_next.run = ~s_next.halt;
        s_next.zoneCode = seqCode(s_next.seq);

        // Pin drive: latched request or thermostat level, both maskable.
        if (s_next.mode) begin
            s_next.alertOe = s_next.intAlert;
        end else begin
            s_next.alertOe = (|s_next.flags) & ~s_next.mask;
        end
    end

    // State register with power-up defaults.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.hiTh[THZAL_ZONE_LOCAL] <= THZAL_HI_LOCAL_RST;
            s_reg.loTh[THZAL_ZONE_LOCAL] <= THZAL_LO_LOCAL_RST;
            s_reg.hiTh[THZAL_ZONE_R1] <= THZAL_HI_REMOTE_RST;
            s_reg.loTh[THZAL_ZONE_R1] <= THZAL_LO_REMOTE_RST;
            s_reg.hiTh[THZAL_ZONE_R2] <= THZAL_HI_REMOTE_RST;
            s_reg.loTh[THZAL_ZONE_R2] <= THZAL_LO_REMOTE_RST;
            s_reg.armedOver <= '1;
            s_reg.seq <= THZAL_SEQ_Z1;
            s_reg.zoneCode <= THZAL_ZCODE_R1;
            s_reg.run <= 1'b1;
            s_reg.depth <= THZAL_DEPTH_1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs taken straight from the state register.
    assign convRun = s_reg.run;
    assign convZone = s_reg.zoneCode;
    assign convRestart = s_reg.restart;
    assign clientAddrBit = s_reg.addrBit;
    assign alertPinOut = s_reg.alertLow;
    assign alertPinOe = s_reg.alertOe;
    assign alertSensed = s_reg.pinSync[1];
    assign haltActive = s_reg.halt;
    assign zoneFlags = s_reg.flags;

endmodule

//--- thzal_alert_chk.sv
/* Port checker for the alert logic, bound to its top module.
   Assumes a synchronous active-low reset on the core clock. */
`timescale 1ns/10ps
module thzal_alert_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic convDone,
    input wire logic convRun,
    input wire logic [1:0] convZone,
    input wire logic convRestart,
    input wire logic haltActive,
    input wire logic [2:0] zoneFlags,
    input wire logic alertPinOut,
    input wire logic alertPinOe,
    input wire logic clientAddrBit
);
    logic [2:0] addrAge;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Counts cycles since reset so the strap check starts after capture.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            addrAge <= 3'h0;
        end else if (addrAge != 3'h7) begin
            addrAge <= addrAge + 3'h1;
        end
    end
    property p_low; alertPinOut == 1'b0; endproperty
    a_low: assert property (p_low) else $error("alert drove high");
    property p_run; convRun == !haltActive; endproperty
    a_run: assert property (p_run) else $error("run and halt");
    property p_halt;
        haltActive |=> (zoneFlags & ~$past(zoneFlags)) == 3'h0;
    endproperty
    a_halt: assert property (p_halt) else $error("flag set halted");
    property p_cause;
        (zoneFlags & ~$past(zoneFlags)) != 3'h0 |-> $past(convDone);
    endproperty
    a_cause: assert property (p_cause) else $error("flag no cause");
    property p_oe; alertPinOe |-> zoneFlags != 3'h0; endproperty
    a_oe: assert property (p_oe) else $error("alert without flag");
    property p_order;
        $changed(convZone) |-> convZone == 2'h1 ||
            (convZone == 2'h2 && $past(convZone) == 2'h1) ||
            (convZone == 2'h0 && $past(convZone) == 2'h2);
    endproperty
    a_order: assert property (p_order) else $error("zone order");
    property p_rst; convRestart |=> !convRestart; endproperty
    a_rst: assert property (p_rst) else $error("restart too long");
    property p_addr; addrAge == 3'h7 |-> $stable(clientAddrBit); endproperty
    a_addr: assert property (p_addr) else $error("strap moved");
endmodule
bind thermal_zone_alert_logic thzal_alert_chk u_chk (.clock(clock),
    .rst_b(rst_b), .convDone(convDone), .convRun(convRun),
    .convZone(convZone), .convRestart(convRestart),
    .haltActive(haltActive), .zoneFlags(zoneFlags),
    .alertPinOut(alertPinOut), .alertPinOe(alertPinOe),
    .clientAddrBit(clientAddrBit));

//--- thzal_host_model.sv
/* Host model: one register request at a time on the link side.
   Assumes a link clock from the bench and the block's handshake. */
`timescale 1ns/10ps
module thzal_host_model
    import thzal_pkg::*;
(
    input wire logic linkClock,
    input wire logic linkReady,
    input wire logic [7:0] busRdData,
    output logic busReq,
    output thzal_req_s busReqData
);
    // Request lines start idle.
    initial begin
        busReq = 1'b0;
        busReqData = '0;
    end
    // Holds the request until taken, then waits for ready to return.
    task automatic xfer(input logic w, input logic [7:0] c,
        input logic [7:0] d, output logic [7:0] q);
        @(negedge linkClock);
        while (!linkReady) @(negedge linkClock);
        busReq = 1'b1;
        busReqData = '{w, c, d};
        @(posedge linkClock);
        @(negedge linkClock);
        busReq = 1'b0;
        busReqData = ~busReqData;
        do @(negedge linkClock); while (!linkReady);
        q = busRdData;
    endtask
endmodule

//--- thermal_zone_alert_logic_test.sv
/* Bench for the alert logic: host model on the link side, converter
   results and strap driven here. Assumes the pin has a pull-up. */
`timescale 1ns/10ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin failCount++; \
    $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module thermal_zone_alert_logic_test;
    import thzal_pkg::*;
    logic clock = 1'b0, linkClock = 1'b0, rst_b = 1'b0, linkRst_b = 1'b0;
    logic convDone = 1'b0, convFault = 1'b0, addrSelectPin = 1'b1;
    logic busReq, linkReady, busRdValid, convRun, convRestart, alertPinIn;
    logic clientAddrBit, alertPinOut, alertPinOe, alertSensed, haltActive;
    logic [7:0] busRdData, q, convReading = 8'h00;
    logic [1:0] convZone;
    logic [2:0] zoneFlags;
    thzal_req_s busReqData;
    int failCount = 0, nCompared = 0;
    int runTab[4] = '{1, 2, 4, 6};
    logic [7:0] cmdTab[6] = '{8'h03, 8'h02, 8'h13, 8'h12, 8'h23, 8'h22};
    logic [7:0] valTab[6] = '{8'h51, 8'h4C, 8'h61, 8'h5C, 8'h61, 8'h5C};
    // Pull-up on the open-drain alert wire.
    assign alertPinIn = alertPinOe ? alertPinOut : 1'b1;
    // Core and link clocks.
    always #10 clock = ~clock;
    always #62.5 linkClock = ~linkClock;
    thermal_zone_alert_logic u_dut (.clock(clock), .rst_b(rst_b),
        .linkClock(linkClock), .linkRst_b(linkRst_b), .busReq(busReq),
        .busReqData(busReqData), .linkReady(linkReady),
        .busRdData(busRdData), .busRdValid(busRdValid),
        .convDone(convDone), .convReading(convReading),
        .convFault(convFault), .convRun(convRun), .convZone(convZone),
        .convRestart(convRestart), .addrSelectPin(addrSelectPin),
        .clientAddrBit(clientAddrBit), .alertPinIn(alertPinIn),
        .alertPinOut(alertPinOut), .alertPinOe(alertPinOe),
        .alertSensed(alertSensed), .haltActive(haltActive),
        .zoneFlags(zoneFlags));
    thzal_host_model u_host (.linkClock(linkClock), .linkReady(linkReady),
        .busRdData(busRdData), .busReq(busReq), .busReqData(busReqData));
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        u_host.xfer(1'b1, c, d, q);
        `CHK(busRdValid, 1'b0)
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        u_host.xfer(1'b0, c, 8'h00, q);
        `CHK(busRdValid, 1'b1)
        `CHK(q, e)
    endtask
    task automatic st(input logic [2:0] f, input logic oe);
        repeat (2) @(negedge clock);
        `CHK(zoneFlags, f)
        `CHK(alertPinOe, oe)
        `CHK(alertSensed, !oe)
    endtask
    // Feeds neutral results until zone z is due, then the given one.
    task automatic feed(input logic [1:0] z, input logic [7:0] r,
        input logic f);
        logic [1:0] cz;
        for (int i = 0; i < 4; i++) begin
            cz = convZone;
            @(negedge clock);
            convDone = 1'b1;
            convFault = (cz == z) ? f : 1'b0;
            convReading = (cz == z) ? r : ((cz == 2'h0) ? 8'h4E : 8'h5E);
            @(negedge clock);
            convDone = 1'b0;
            @(negedge clock);
            if (cz == z) break;
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #400000;
        failCount++;
        report_and_stop;
    end
    // Main sequence.
    initial begin
        repeat (8) @(negedge clock);
        rst_b = 1'b1;
        repeat (12) @(negedge clock);
        linkRst_b = 1'b1;
        `CHK(clientAddrBit, 1'b1)
        addrSelectPin = 1'b0;
        repeat (20) @(negedge clock);
        `CHK(clientAddrBit, 1'b1)
        `CHK(convZone, 2'h1)
        st(3'h0, 1'b0);
        rd(8'h01, 8'h00);
        foreach (cmdTab[i]) rd(cmdTab[i], valTab[i]);
        rd(8'h47, 8'h00);
        $display("test defaults done");
        for (int d = 0; d < 4; d++) begin
            wr(8'h01, {3'b000, d[1:0], 3'b000});
            repeat (runTab[d] - 1) feed(2'h1, 8'h62, 1'b0);
            feed(2'h1, 8'h61, 1'b0);
            repeat (runTab[d] - 1) feed(2'h1, 8'h62, 1'b0);
            st(3'h0, 1'b0);
            feed(2'h1, 8'h62, 1'b0);
            st(3'h2, 1'b1);
            repeat (runTab[d] - 1) feed(2'h1, 8'h5B, 1'b0);
            st(3'h2, 1'b1);
            feed(2'h1, 8'h5B, 1'b0);
            st(3'h0, 1'b0);
        end
        $display("test depth done");
        wr(8'h01, 8'h02);
        feed(2'h0, 8'h52, 1'b0);
        st(3'h1, 1'b1);
        rd(8'h01, 8'h82);
        st(3'h0, 1'b0);
        rd(8'h00, 8'h52);
        feed(2'h0, 8'h52, 1'b0);
        st(3'h0, 1'b0);
        feed(2'h0, 8'h4B, 1'b0);
        st(3'h1, 1'b1);
        rd(8'h00, 8'h4B);
        st(3'h1, 1'b0);
        feed(2'h0, 8'h52, 1'b0);
        st(3'h1, 1'b1);
        wr(8'h01, 8'h03);
        st(3'h0, 1'b0);
        `CHK(convRun, 1'b0)
        rd(8'h02, 8'h4C);
        feed(2'h1, 8'h62, 1'b0);
        st(3'h0, 1'b0);
        wr(8'h01, 8'h02);
        `CHK(convZone, 2'h1)
        $display("test interrupt done");
        wr(8'h01, 8'h06);
        feed(2'h2, 8'h62, 1'b0);
        st(3'h4, 1'b0);
        feed(2'h2, 8'h62, 1'b0);
        rd(8'h01, 8'h26);
        feed(2'h1, 8'h5E, 1'b1);
        st(3'h2, 1'b0);
        rd(8'h01, 8'h46);
        wr(8'h01, 8'h00);
        feed(2'h1, 8'h62, 1'b0);
        st(3'h2, 1'b1);
        wr(8'h01, 8'h01);
        st(3'h2, 1'b1);
        rd(8'h01, 8'h41);
        $display("test mask and halt done");
        report_and_stop;
    end
endmodule
